// [src/tid_consts.vh]
// constants for the tap instruction decoder and its data registers
`ifndef TID_CONSTS_VH
`define TID_CONSTS_VH

// register lengths and pin count
`define TID_IR_LEN        23
`define TID_ID_LEN        32
`define TID_GREG_LEN      97
`define TID_NPINS         8
`define TID_BSR_LEN       24

// instruction codes
`define TID_OP_BYPASS     23'h000000
`define TID_OP_EXTEST     23'h7fffe8
`define TID_OP_EXT_PULSE  23'h7fffe9
`define TID_OP_EXT_TRAIN  23'h7fffea
`define TID_OP_SAMPLE     23'h7ffff8
`define TID_OP_IDCODE     23'h7fffff
`define TID_OP_HIGHZ      23'h7fffcf
`define TID_OP_CLAMP      23'h7ffffe
`define TID_OP_GREG       23'h00003d

// capture and reset values
`define TID_IR_CAPTURE    23'h000001
// identification value is arbitrary; bit 0 set as the identification register demands
`define TID_IDCODE_VALUE  32'h0a5a5001
`define TID_GREG_RESET    97'h0

// data register selection codes
`define TID_DR_BYPASS     2'h0
`define TID_DR_BSR        2'h1
`define TID_DR_ID         2'h2
`define TID_DR_GREG       2'h3

// pin drive modes
`define TID_PIN_NORMAL    2'h0
`define TID_PIN_TEST      2'h1
`define TID_PIN_HIGHZ     2'h2

// tap controller states
`define TID_ST_TLR        4'h0
`define TID_ST_RTI        4'h1
`define TID_ST_SEL_DR     4'h2
`define TID_ST_CAP_DR     4'h3
`define TID_ST_SH_DR      4'h4
`define TID_ST_EX1_DR     4'h5
`define TID_ST_PA_DR      4'h6
`define TID_ST_EX2_DR     4'h7
`define TID_ST_UPD_DR     4'h8
`define TID_ST_SEL_IR     4'h9
`define TID_ST_CAP_IR     4'ha
`define TID_ST_SH_IR      4'hb
`define TID_ST_EX1_IR     4'hc
`define TID_ST_PA_IR      4'hd
`define TID_ST_EX2_IR     4'he
`define TID_ST_UPD_IR     4'hf

`endif

// [src/tid_bscan_chain.v]
// boundary-scan register with capture, shift and update latches
`timescale 1ns/1ps
`include "tid_consts.vh"

module tid_bscan_chain (
  input  wire                    i_ref_clk,
  input  wire                    i_rst_n,
  input  wire                    i_capture,
  input  wire                    i_shift,
  input  wire                    i_update,
  input  wire                    i_tdi,
  input  wire [`TID_NPINS-1:0]   i_pin_in,
  input  wire [`TID_NPINS-1:0]   i_core_out,
  input  wire [`TID_NPINS-1:0]   i_core_oe,
  output wire                    o_so,
  output wire [`TID_NPINS-1:0]   o_upd_out,
  output wire [`TID_NPINS-1:0]   o_upd_oe
);

  // cell order from tdi side: oe cells, output cells, input cells nearest tdo
  wire [`TID_BSR_LEN-1:0] cap_val;
  wire [`TID_BSR_LEN:0]   chain;
  reg  [`TID_BSR_LEN-1:0] sh;
  reg  [`TID_BSR_LEN-1:0] upd;

  assign cap_val = {i_core_oe, i_core_out, i_pin_in};
  assign chain[`TID_BSR_LEN] = i_tdi;

  genvar g;
  generate
    for (g = 0; g < `TID_BSR_LEN; g = g + 1) begin : g_cell
      assign chain[g] = sh[g];
      always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sh[g]  <= 1'b0;
          upd[g] <= 1'b0;
        end else begin
          if (i_capture) begin
            sh[g] <= cap_val[g];
          end else if (i_shift) begin
            sh[g] <= chain[g+1];
          end
          // latch holds preloaded data until the next update, so a later extest drives it
          if (i_update) begin
            upd[g] <= sh[g];
          end
        end
      end
    end
  endgenerate

  assign o_so      = sh[0];
  assign o_upd_out = upd[2*`TID_NPINS-1:`TID_NPINS];
  assign o_upd_oe  = upd[3*`TID_NPINS-1:2*`TID_NPINS];

endmodule // tid_bscan_chain

// [src/tid_tap_decode.v]
// tap controller, instruction decode and data register selection
`timescale 1ns/1ps
`include "tid_consts.vh"
// Functional notes
// - bypass puts one-bit register between tdi, tdo
// - extest drives pins from boundary update latches
// - extest captures input pins before shifting
// - extest pulse gives one pulse per idle visit
// - extest train pulses continuously while in idle
// - sample keeps pins normal, captures pins and core
// - preloaded values held in update latches
// - idcode connects 32-bit identification register
// - reset or test-logic-reset selects identification register
// - highz floats all outputs, bypass selected
// - clamp drives latches, shifts through bypass
// - global instruction connects 97-bit internal register
// - sample tms/tdi on rise, tdo on fall
// - runs from reference clock, test clock oversampled, always active

module tid_tap_decode (
  input  wire                      i_ref_clk,
  input  wire                      i_rst_n,
  input  wire                      i_tck,
  input  wire                      i_tms,
  input  wire                      i_tdi,
  input  wire                      i_trst_n,
  input  wire [`TID_NPINS-1:0]     i_pin_in,
  input  wire [`TID_NPINS-1:0]     i_core_out,
  input  wire [`TID_NPINS-1:0]     i_core_oe,
  input  wire [`TID_GREG_LEN-1:0]  i_global_status,
  output reg                       o_tdo,
  output reg                       o_tdo_oe,
  output reg  [`TID_NPINS-1:0]     o_pin_out,
  output reg  [`TID_NPINS-1:0]     o_pin_oe,
  output reg                       o_test_pulse,
  output reg  [`TID_GREG_LEN-1:0]  o_global_cfg,
  output reg  [`TID_IR_LEN-1:0]    o_instr
);

  localparam [3:0] ST_TLR    = `TID_ST_TLR;
  localparam [3:0] ST_RTI    = `TID_ST_RTI;
  localparam [3:0] ST_SEL_DR = `TID_ST_SEL_DR;
  localparam [3:0] ST_CAP_DR = `TID_ST_CAP_DR;
  localparam [3:0] ST_SH_DR  = `TID_ST_SH_DR;
  localparam [3:0] ST_EX1_DR = `TID_ST_EX1_DR;
  localparam [3:0] ST_PA_DR  = `TID_ST_PA_DR;
  localparam [3:0] ST_EX2_DR = `TID_ST_EX2_DR;
  localparam [3:0] ST_UPD_DR = `TID_ST_UPD_DR;
  localparam [3:0] ST_SEL_IR = `TID_ST_SEL_IR;
  localparam [3:0] ST_CAP_IR = `TID_ST_CAP_IR;
  localparam [3:0] ST_SH_IR  = `TID_ST_SH_IR;
  localparam [3:0] ST_EX1_IR = `TID_ST_EX1_IR;
  localparam [3:0] ST_PA_IR  = `TID_ST_PA_IR;
  localparam [3:0] ST_EX2_IR = `TID_ST_EX2_IR;
  localparam [3:0] ST_UPD_IR = `TID_ST_UPD_IR;

  // which data register an instruction selects
  function [1:0] tid_dr_sel;
    input [`TID_IR_LEN-1:0] op;
    begin
      case (op)
        `TID_OP_EXTEST:    tid_dr_sel = `TID_DR_BSR;
        `TID_OP_EXT_PULSE: tid_dr_sel = `TID_DR_BSR;
        `TID_OP_EXT_TRAIN: tid_dr_sel = `TID_DR_BSR;
        `TID_OP_SAMPLE:    tid_dr_sel = `TID_DR_BSR;
        `TID_OP_IDCODE:    tid_dr_sel = `TID_DR_ID;
        `TID_OP_GREG:      tid_dr_sel = `TID_DR_GREG;
        `TID_OP_BYPASS:    tid_dr_sel = `TID_DR_BYPASS;
        `TID_OP_HIGHZ:     tid_dr_sel = `TID_DR_BYPASS;
        `TID_OP_CLAMP:     tid_dr_sel = `TID_DR_BYPASS;
        default:           tid_dr_sel = `TID_DR_BYPASS;
      endcase
    end
  endfunction

  // how the output pins are driven under an instruction
  function [1:0] tid_pin_mode;
    input [`TID_IR_LEN-1:0] op;
    begin
      case (op)
        `TID_OP_EXTEST:    tid_pin_mode = `TID_PIN_TEST;
        `TID_OP_EXT_PULSE: tid_pin_mode = `TID_PIN_TEST;
        `TID_OP_EXT_TRAIN: tid_pin_mode = `TID_PIN_TEST;
        `TID_OP_CLAMP:     tid_pin_mode = `TID_PIN_TEST;
        `TID_OP_HIGHZ:     tid_pin_mode = `TID_PIN_HIGHZ;
        default:           tid_pin_mode = `TID_PIN_NORMAL;
      endcase
    end
  endfunction

  // pin synchronisers; first stages feed only second stages
  reg                  tck_s1;
  reg                  tck_s2;
  reg                  tck_d;
  reg                  tms_s1;
  reg                  tms_s2;
  reg                  tdi_s1;
  reg                  tdi_s2;
  reg                  trst_s1;
  reg                  trst_s2;
  reg [`TID_NPINS-1:0] pin_s1;
  reg [`TID_NPINS-1:0] pin_s2;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tck_s1  <= 1'b0;
      tck_s2  <= 1'b0;
      tck_d   <= 1'b0;
      tms_s1  <= 1'b1;
      tms_s2  <= 1'b1;
      tdi_s1  <= 1'b0;
      tdi_s2  <= 1'b0;
      trst_s1 <= 1'b0;
      trst_s2 <= 1'b0;
      pin_s1  <= {`TID_NPINS{1'b0}};
      pin_s2  <= {`TID_NPINS{1'b0}};
    end else begin
      tck_s1  <= i_tck;
      tck_s2  <= tck_s1;
      tck_d   <= tck_s2;
      tms_s1  <= i_tms;
      tms_s2  <= tms_s1;
      tdi_s1  <= i_tdi;
      tdi_s2  <= tdi_s1;
      trst_s1 <= i_trst_n;
      trst_s2 <= trst_s1;
      pin_s1  <= i_pin_in;
      pin_s2  <= pin_s1;
    end
  end

  // all tap activity except test reset and the i_rst_n reset is paced by test clock edges, never by core state
  wire tck_rise = tck_s2 & ~tck_d;
  wire tck_fall = ~tck_s2 & tck_d;

  reg  [3:0] state;
  reg  [3:0] next_state;

  always @* begin
    case (state)
      ST_TLR:    next_state = tms_s2 ? ST_TLR    : ST_RTI;
      ST_RTI:    next_state = tms_s2 ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_state = tms_s2 ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_s2 ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = tms_s2 ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms_s2 ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  next_state = tms_s2 ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = tms_s2 ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms_s2 ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_state = tms_s2 ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_s2 ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = tms_s2 ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms_s2 ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  next_state = tms_s2 ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = tms_s2 ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms_s2 ? ST_SEL_DR : ST_RTI;
      default:   next_state = ST_TLR;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_TLR;
    end else if (!trst_s2) begin
      state <= ST_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // instruction register: shift stage plus active latch
  reg  [`TID_IR_LEN-1:0] ir_sh;
  wire [1:0]             dr_sel = tid_dr_sel(o_instr);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ir_sh   <= `TID_IR_CAPTURE;
      o_instr <= `TID_OP_IDCODE;
    end else begin
      if (tck_rise && state == ST_CAP_IR) begin
        ir_sh <= `TID_IR_CAPTURE;
      end else if (tck_rise && state == ST_SH_IR) begin
        ir_sh <= {tdi_s2, ir_sh[`TID_IR_LEN-1:1]};
      end
      if (state == ST_TLR) begin
        o_instr <= `TID_OP_IDCODE;
      end else if (tck_fall && state == ST_UPD_IR) begin
        o_instr <= ir_sh;
      end
    end
  end

  wire dr_cap = tck_rise && state == ST_CAP_DR;
  wire dr_sh  = tck_rise && state == ST_SH_DR;
  wire dr_upd = tck_fall && state == ST_UPD_DR;

  // bypass, identification and global registers
  reg                      byp;
  reg [`TID_ID_LEN-1:0]    id_sh;
  reg [`TID_GREG_LEN-1:0]  greg_sh;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      byp          <= 1'b0;
      id_sh        <= `TID_IDCODE_VALUE;
      greg_sh      <= `TID_GREG_RESET;
      o_global_cfg <= `TID_GREG_RESET;
    end else begin
      if (dr_sel == `TID_DR_BYPASS) begin
        if (dr_cap) begin
          byp <= 1'b0;
        end else if (dr_sh) begin
          byp <= tdi_s2;
        end
      end
      if (dr_sel == `TID_DR_ID) begin
        if (dr_cap) begin
          id_sh <= `TID_IDCODE_VALUE;
        end else if (dr_sh) begin
          id_sh <= {tdi_s2, id_sh[`TID_ID_LEN-1:1]};
        end
      end
      if (dr_sel == `TID_DR_GREG) begin
        if (dr_cap) begin
          greg_sh <= i_global_status;
        end else if (dr_sh) begin
          greg_sh <= {tdi_s2, greg_sh[`TID_GREG_LEN-1:1]};
        end
        if (dr_upd) begin
          o_global_cfg <= greg_sh;
        end
      end
    end
  end

  // boundary-scan register
  wire                  bsr_so;
  wire [`TID_NPINS-1:0] upd_out;
  wire [`TID_NPINS-1:0] upd_oe;
  wire                  bsr_on = (dr_sel == `TID_DR_BSR);

  tid_bscan_chain u_bsr (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_capture  (dr_cap && bsr_on),
    .i_shift    (dr_sh && bsr_on),
    .i_update   (dr_upd && bsr_on),
    .i_tdi      (tdi_s2),
    .i_pin_in   (pin_s2),
    .i_core_out (i_core_out),
    .i_core_oe  (i_core_oe),
    .o_so       (bsr_so),
    .o_upd_out  (upd_out),
    .o_upd_oe   (upd_oe)
  );

  // serial output changes only on falling test clock edges
  reg dr_so;

  always @* begin
    case (dr_sel)
      `TID_DR_BSR:  dr_so = bsr_so;
      `TID_DR_ID:   dr_so = id_sh[0];
      `TID_DR_GREG: dr_so = greg_sh[0];
      default:      dr_so = byp;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      if (state == ST_SH_DR) begin
        o_tdo    <= dr_so;
        o_tdo_oe <= 1'b1;
      end else if (state == ST_SH_IR) begin
        o_tdo    <= ir_sh[0];
        o_tdo_oe <= 1'b1;
      end else begin
        o_tdo_oe <= 1'b0;
      end
    end
  end

  // ac test pulse: one per idle visit, or a train toggling each rise in idle
  reg ac_lvl;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ac_lvl <= 1'b0;
    end else if (o_instr == `TID_OP_EXT_PULSE) begin
      ac_lvl <= (state == ST_RTI);
    end else if (o_instr == `TID_OP_EXT_TRAIN && state == ST_RTI) begin
      if (tck_rise) begin
        ac_lvl <= ~ac_lvl;
      end
    end else begin
      ac_lvl <= 1'b0;
    end
  end

  // pin drive; the pulse is laid over the latched test data
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_out    <= {`TID_NPINS{1'b0}};
      o_pin_oe     <= {`TID_NPINS{1'b0}};
      o_test_pulse <= 1'b0;
    end else begin
      o_test_pulse <= ac_lvl;
      case (tid_pin_mode(o_instr))
        `TID_PIN_TEST: begin
          o_pin_out <= upd_out ^ {`TID_NPINS{ac_lvl}};
          o_pin_oe  <= upd_oe;
        end
        `TID_PIN_HIGHZ: begin
          o_pin_out <= {`TID_NPINS{1'b0}};
          o_pin_oe  <= {`TID_NPINS{1'b0}};
        end
        default: begin
          o_pin_out <= i_core_out;
          o_pin_oe  <= i_core_oe;
        end
      endcase
    end
  end

endmodule // tid_tap_decode

// [bench/tid_tap_decode_sva.sv]
// port assertions for the tap instruction decoder
`timescale 1ns/1ps
`include "tid_consts.vh"

module tid_tap_decode_sva (
  input wire                     i_ref_clk,
  input wire                     i_rst_n,
  input wire                     i_tck,
  input wire                     i_tms,
  input wire                     i_tdi,
  input wire                     i_trst_n,
  input wire [`TID_NPINS-1:0]    i_pin_in,
  input wire [`TID_NPINS-1:0]    i_core_out,
  input wire [`TID_NPINS-1:0]    i_core_oe,
  input wire [`TID_GREG_LEN-1:0] i_global_status,
  input wire                     o_tdo,
  input wire                     o_tdo_oe,
  input wire [`TID_NPINS-1:0]    o_pin_out,
  input wire [`TID_NPINS-1:0]    o_pin_oe,
  input wire                     o_test_pulse,
  input wire [`TID_GREG_LEN-1:0] o_global_cfg,
  input wire [`TID_IR_LEN-1:0]   o_instr
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  reset_picks_id_a: assert property ($rose(i_rst_n) |-> o_instr == `TID_OP_IDCODE)
    else $error("instruction not id after reset");
  // six low samples cover the two-stage synchroniser, the state register and the instruction latch
  trst_picks_id_a: assert property ((!i_trst_n)[*6] |-> o_instr == `TID_OP_IDCODE)
    else $error("instruction not id under test reset");
  highz_floats_a: assert property ((o_instr == `TID_OP_HIGHZ)[*3] |-> o_pin_oe == 8'h00)
    else $error("pins driven under highz");
  sample_normal_a: assert property ((o_instr == `TID_OP_SAMPLE)[*3] |->
    o_pin_out == $past(i_core_out) && o_pin_oe == $past(i_core_oe))
    else $error("pins not normal under sample");
  clamp_holds_a: assert property ((o_instr == `TID_OP_CLAMP)[*3] |-> $stable(o_pin_out) && $stable(o_pin_oe))
    else $error("pins moved under clamp");
  pulse_gated_a: assert property ((!(o_instr == `TID_OP_EXT_PULSE || o_instr == `TID_OP_EXT_TRAIN))[*3]
    |-> !o_test_pulse)
    else $error("test pulse without pulse instruction");
  tdo_on_fall_a: assert property ($changed(o_tdo) |-> !i_tck && !$past(i_tck, 2))
    else $error("serial out moved away from a falling test clock");
  tdo_oe_on_fall_a: assert property ($changed(o_tdo_oe) |-> !i_tck && !$past(i_tck, 2))
    else $error("serial out enable moved away from a falling test clock");
  greg_on_update_a: assert property ($changed(o_global_cfg) |-> o_instr == `TID_OP_GREG)
    else $error("global config changed under another instruction");
endmodule // tid_tap_decode_sva

bind tid_tap_decode tid_tap_decode_sva u_tid_tap_decode_sva (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
  .i_trst_n(i_trst_n), .i_pin_in(i_pin_in), .i_core_out(i_core_out), .i_core_oe(i_core_oe),
  .i_global_status(i_global_status), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .o_test_pulse(o_test_pulse), .o_global_cfg(o_global_cfg), .o_instr(o_instr)
);

// [bench/tid_jtag_tester.sv]
// boundary-scan tester model driving the test port pins
`timescale 1ns/1ps

module tid_jtag_tester (
  input  wire logic i_ref_clk,
  input  wire logic i_tdo,
  input  wire logic i_tdo_oe,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  output logic      o_trst_n
);
  logic [127:0] shot;
  event         done;

  // test clock stands low between frames
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end

  // 160 ns test clock; tms/tdi move at the fall, tdo taken at the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (8) @(negedge i_ref_clk);
    // a released line reads inverted, so a bit taken outside the enable window shows up
    tdo = i_tdo_oe ? i_tdo : ~i_tdo;
    o_tck = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    o_tck = 1'b0;
  endtask

  // tms bits taken lsb first
  task automatic walk(input logic [7:0] seq, input int n);
    logic d;
    for (int i = 0; i < n; i++) step(seq[i], o_tdi, d);
  endtask

  // from idle through shift and update back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic d;
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    walk(8'h01, 2);
    o_tdi = ~din[n-1];
    shot = dout;
    -> done;
  endtask

  task automatic hold_trst();
    logic d;
    o_trst_n = 1'b0;
    repeat (8) @(negedge i_ref_clk);
    o_trst_n = 1'b1;
    step(1'b0, o_tdi, d);
  endtask
endmodule // tid_jtag_tester

// [bench/test_tap_instruction_decode.sv]
// self-checking bench for the tap instruction decoder
`timescale 1ns/1ps
`include "tid_consts.vh"

module test_tap_instruction_decode;
  typedef struct packed {logic [127:0] m; logic [127:0] v;} tid_note_t;
  logic                     i_ref_clk = 1'b0;
  logic                     i_rst_n = 1'b0;
  logic [`TID_NPINS-1:0]    pin_in = '0, core_out = '0, core_oe = '0;
  logic [`TID_GREG_LEN-1:0] status = '0;
  wire                      tck, tms, tdi, trst_n, tdo, tdo_oe, pulse;
  wire  [`TID_NPINS-1:0]    pin_out, pin_oe;
  wire  [`TID_GREG_LEN-1:0] cfg;
  wire  [`TID_IR_LEN-1:0]   instr;
  tid_note_t                notes[$];
  tid_note_t                nt;
  int                       error_cnt = 0;
  int                       comparisons = 0;
  int                       len;
  logic [31:0]              rng = 32'd63397;
  logic [127:0]             din, dout, pre, exp, msk;
  logic                     v1;
  logic [`TID_IR_LEN-1:0]   ops [10] = '{`TID_OP_BYPASS, `TID_OP_HIGHZ, 23'h123456, `TID_OP_IDCODE,
    `TID_OP_SAMPLE, `TID_OP_EXTEST, `TID_OP_CLAMP, `TID_OP_EXT_PULSE, `TID_OP_EXT_TRAIN, `TID_OP_GREG};

  always #5 i_ref_clk = ~i_ref_clk;

  tid_tap_decode u_tid_tap_decode (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n),
    .i_pin_in(pin_in), .i_core_out(core_out), .i_core_oe(core_oe), .i_global_status(status),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_test_pulse(pulse),
    .o_global_cfg(cfg), .o_instr(instr));
  tid_jtag_tester u_tid_jtag_tester (
    .i_ref_clk(i_ref_clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .o_trst_n(trst_n));

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk_val(input logic [127:0] got, input logic [127:0] want);
    comparisons++;
    if (got !== want) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // oldest note against each finished scan
  initial forever begin
    @(u_tid_jtag_tester.done);
    nt = notes.pop_front();
    chk_val(u_tid_jtag_tester.shot & nt.m, nt.v);
  end

  initial begin
    #800000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge i_ref_clk);
    @(negedge i_ref_clk) i_rst_n = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    chk_val(instr, `TID_OP_IDCODE);
    u_tid_jtag_tester.walk(8'h1f, 6);
    din = {rnd(), rnd(), rnd(), rnd()};
    notes.push_back('{~128'h0 >> 96, `TID_IDCODE_VALUE});
    u_tid_jtag_tester.scan(1'b0, 32, din, dout);
    for (int k = 0; k < 10; k++) begin
      @(negedge i_ref_clk);
      din = {rnd(), rnd(), rnd(), rnd()};
      {core_oe, core_out, pin_in} = din[23:0];
      status = din[96:0];
      notes.push_back('{~128'h0 >> 105, 128'h1});
      u_tid_jtag_tester.scan(1'b1, 23, {105'h0, ops[k]}, dout);
      chk_val(instr, ops[k]);
      chk_val(tdo_oe, 1'b0);
      if (ops[k] == `TID_OP_HIGHZ) chk_val(pin_oe, 8'h00);
      // bypass captures zero and delays the stream by one bit
      len = 8;
      exp = {din[126:0], 1'b0};
      if (ops[k] == `TID_OP_SAMPLE || ops[k] == `TID_OP_EXTEST) len = 24;
      if (ops[k] == `TID_OP_SAMPLE) exp = {core_oe, core_out, pin_in};
      if (ops[k] == `TID_OP_EXTEST) exp = pin_in;
      if (ops[k] == `TID_OP_IDCODE) len = 32;
      if (ops[k] == `TID_OP_IDCODE) exp = `TID_IDCODE_VALUE;
      if (ops[k] == `TID_OP_GREG) len = 97;
      if (ops[k] == `TID_OP_GREG) exp = status;
      if (ops[k] == `TID_OP_EXT_PULSE || ops[k] == `TID_OP_EXT_TRAIN) len = 0;
      msk = ~128'h0 >> (128 - ((ops[k] == `TID_OP_EXTEST) ? 8 : len));
      if (ops[k] == `TID_OP_EXTEST || ops[k] == `TID_OP_CLAMP) chk_val({pin_oe, pin_out}, pre[23:8]);
      if (len > 0) begin
        notes.push_back('{msk, exp & msk});
        u_tid_jtag_tester.scan(1'b0, len, din, dout);
      end
      repeat (4) @(negedge i_ref_clk);
      if (ops[k] == `TID_OP_SAMPLE) chk_val({pin_oe, pin_out}, {core_oe, core_out});
      if (ops[k] == `TID_OP_SAMPLE || ops[k] == `TID_OP_EXTEST) pre = din;
      if (ops[k] == `TID_OP_EXTEST || ops[k] == `TID_OP_CLAMP) chk_val({pin_oe, pin_out}, pre[23:8]);
      if (ops[k] == `TID_OP_GREG) chk_val(cfg, din[96:0]);
      if (len == 0) begin
        u_tid_jtag_tester.walk(8'h00, 1);
        v1 = pulse;
        u_tid_jtag_tester.walk(8'h00, 1);
        chk_val({v1, pulse}, (ops[k] == `TID_OP_EXT_PULSE) ? 2'b11 : 2'b10);
        u_tid_jtag_tester.walk(8'h01, 1);
        repeat (4) @(negedge i_ref_clk);
        chk_val(pulse, 1'b0);
        u_tid_jtag_tester.walk(8'h06, 4);
      end
      $display("test %0d done", k);
    end
    u_tid_jtag_tester.hold_trst();
    chk_val(instr, `TID_OP_IDCODE);
    wrap_up();
  end
endmodule // test_tap_instruction_decode
